// ---- src/uart_flow_pkg.sv ----
`default_nettype none
package uart_flow_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_EFR    = 8'h00;  // enhanced_feature_reg
    localparam logic [7:0] OFS_IER    = 8'h04;  // interrupt_enable_reg
    localparam logic [7:0] OFS_FCR    = 8'h08;  // fifo_control_reg
    localparam logic [7:0] OFS_MCR    = 8'h0c;  // modem_control_reg
    localparam logic [7:0] OFS_MODE   = 8'h10;  // fifo size mode
    localparam logic [7:0] OFS_UPPER  = 8'h14;  // upper_threshold
    localparam logic [7:0] OFS_LOWER  = 8'h18;  // lower_threshold
    localparam logic [7:0] OFS_RESUME_CHAR_FIRST   = 8'h1c;  // resume_char_first
    localparam logic [7:0] OFS_RESUME_CHAR_SECOND   = 8'h20;  // resume_char_second
    localparam logic [7:0] OFS_PAUSE_CHAR_FIRST  = 8'h24;  // pause_char_first
    localparam logic [7:0] OFS_PAUSE_CHAR_SECOND  = 8'h28;  // pause_char_second
    localparam logic [7:0] OFS_FSR    = 8'h2c;  // flow_status_reg
    localparam logic [7:0] OFS_ISR    = 8'h30;  // interrupt_status_reg
    localparam logic [7:0] OFS_MSR    = 8'h34;  // modem_status_reg
    localparam logic [7:0] OFS_LSR    = 8'h38;  // line_status_reg

    // field positions
    localparam int EFR_CTS_GATE  = 7;
    localparam int IER_CTS_INT   = 7;
    localparam int IER_XOFF_INT  = 5;
    localparam int MCR_ANY_RES   = 5;
    localparam int FSR_RX_XOFF   = 0;
    localparam int FSR_CTS       = 1;
    localparam int FSR_TX_XOFF   = 4;
    localparam int MSR_CTS_LEVEL = 4;
    localparam int MSR_CTS_DELTA = 0;
    localparam int LSR_THR_EMPTY = 5;
    localparam int LSR_TX_EMPTY  = 6;

    // interrupt status codes
    localparam logic [5:0] ISR_NONE = 6'h01;
    localparam logic [5:0] ISR_XOFF = 6'h10;
    localparam logic [5:0] ISR_CTS  = 6'h20;

    // reset values
    localparam logic [7:0] RST_REG   = 8'h00;
    localparam logic [7:0] RST_XON   = 8'h11;
    localparam logic [7:0] RST_XOFF  = 8'h13;
    localparam logic [8:0] RST_UPPER = 9'h03c;
    localparam logic [8:0] RST_LOWER = 9'h000;

    // 64-byte mode thresholds
    localparam logic [8:0] UP_T0 = 9'd8;
    localparam logic [8:0] UP_T1 = 9'd16;
    localparam logic [8:0] UP_T2 = 9'd56;
    localparam logic [8:0] UP_T3 = 9'd60;
    localparam logic [8:0] LO_T0 = 9'd0;
    localparam logic [8:0] LO_T1 = 9'd8;
    localparam logic [8:0] LO_T2 = 9'd16;
    localparam logic [8:0] LO_T3 = 9'd56;

    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage
`default_nettype wire

// ---- src/uart_flow_control.sv ----
// Decided for this implementation: the address map and register access over AXI4-Lite.
`default_nettype none
module uart_flow_control
    import uart_flow_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // modem pin
    input  wire logic        cts_n,
    // receiver side
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_parity_err,
    input  wire logic [8:0]  rx_count,
    output logic             store_valid,
    output logic [7:0]       store_data,
    output logic             store_parity_err,
    // tx fifo and shifter
    input  wire logic        txq_valid,
    input  wire logic [7:0]  txq_data,
    output logic             txq_ready,
    input  wire logic        tx_space,
    input  wire logic        tx_busy,
    output logic             tx_start,
    output logic [7:0]       tx_char,
    // interrupt level
    output logic             flow_irq
);
    // ---------------- registers ----------------
    logic [7:0] efr_r, ier_r, fcr_r, mcr_r, mode_r, resume_char_first_r, resume_char_second_r, pause_char_first_r, pause_char_second_r;
    logic [8:0] upper_r, lower_r;
    logic       cts_meta_r, cts_sync_r, cts_prev_r;
    logic       cts_int_r, xoff_int_r, cts_delta_r;
    logic       tx_xoff_r, rx_xoff_r;
    logic [1:0] pend_cnt_r;
    logic       pend_off_r;
    logic       start_r;
    logic [7:0] tx_char_r;
    logic       held_on_r, held_off_r;
    logic [7:0] held_char_r;
    logic       store_v_r, store_p_r, defer_v_r, defer_p_r;
    logic [7:0] store_d_r, defer_d_r;
    logic       aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;

    // ---------------- bus decode ----------------
    wire        wr_fire  = aw_hold_r && w_hold_r && !bvalid_r;
    wire        wr_b0    = wr_fire && w_strb_r[0];
    wire [7:0]  wd       = w_data_r[7:0];
    wire        big_mode = mode_r[0];
    wire        wr_ok    = (aw_addr_r <= OFS_PAUSE_CHAR_SECOND) && (aw_addr_r[1:0] == 2'b00);
    wire        rd_fire  = s_axi_arvalid && !rvalid_r;
    wire        rd_isr   = rd_fire && s_axi_araddr == OFS_ISR;
    wire        rd_msr   = rd_fire && s_axi_araddr == OFS_MSR;

    assign s_axi_awready = !aw_hold_r;
    assign s_axi_wready  = !w_hold_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // ---------------- thresholds ----------------
    wire [8:0] up_tab = fcr_r[7] ? (fcr_r[6] ? UP_T3 : UP_T2) : (fcr_r[6] ? UP_T1 : UP_T0);
    wire [8:0] lo_tab = fcr_r[5] ? (fcr_r[4] ? LO_T3 : LO_T2) : (fcr_r[4] ? LO_T1 : LO_T0);
    // in 256 mode the host owns both values and must keep upper above lower
    wire [8:0] upper_eff = big_mode ? upper_r : up_tab;
    wire [8:0] lower_eff = big_mode ? lower_r : lo_tab;

    // ---------------- control decode ----------------
    wire cts_gate  = efr_r[EFR_CTS_GATE];
    wire tx_sw_on  = efr_r[3] | efr_r[2];
    wire rx_sw_on  = efr_r[1] | efr_r[0];
    wire rx_two    = efr_r[1] & efr_r[0];
    wire any_res   = mcr_r[MCR_ANY_RES] && rx_xoff_r;
    wire cts_high  = cts_sync_r;

    // fifo size mode deliberately absent from the pause terms
    wire paused    = (cts_gate && cts_high) || (rx_sw_on && rx_xoff_r);
    wire boundary  = !tx_busy && !start_r;

    // ---------------- receive recognition ----------------
    wire [7:0] cmp_on  = efr_r[1] ? resume_char_first_r : resume_char_second_r;
    wire [7:0] cmp_off = efr_r[1] ? pause_char_first_r : pause_char_second_r;
    // parity error never enters the compare so errored flow chars still act
    wire hit_on    = rx_data == cmp_on;
    wire hit_off   = (rx_data == cmp_off) && !hit_on;
    wire is_on1    = rx_data == resume_char_first_r;
    wire is_off1   = rx_data == pause_char_first_r;
    wire pair_on   = held_on_r && rx_data == resume_char_second_r;
    wire pair_off  = held_off_r && rx_data == pause_char_second_r && !pair_on;
    wire first_hit = !pair_on && !pair_off && (is_on1 || is_off1);
    wire held_any  = held_on_r || held_off_r;

    wire sel_on    = rx_two ? pair_on : hit_on;
    wire sel_off   = rx_two ? pair_off : hit_off;
    wire consumed  = rx_sw_on && (rx_two ? (pair_on || pair_off || first_hit) : (hit_on || hit_off));
    wire go_xon    = rx_valid && rx_sw_on && (sel_on || any_res);
    wire go_xoff   = rx_valid && rx_sw_on && sel_off && !any_res;
    wire flush     = rx_valid && rx_sw_on && rx_two && held_any && !consumed;

    // ---------------- transmit scheduling ----------------
    wire       tx_go_off = tx_sw_on && !tx_xoff_r && rx_count > upper_eff && pend_cnt_r == 2'd0;
    wire       tx_go_on  = tx_sw_on && tx_xoff_r && rx_count == lower_eff && pend_cnt_r == 2'd0;
    wire       pair_tx   = efr_r[3] & efr_r[2];
    wire       use_first = efr_r[3] && (pend_cnt_r == 2'd2 || !efr_r[2]);
    wire [7:0] flow_char = pend_off_r ? (use_first ? pause_char_first_r : pause_char_second_r)
                                      : (use_first ? resume_char_first_r : resume_char_second_r);
    wire       send_flow = boundary && pend_cnt_r != 2'd0;
    assign txq_ready = boundary && pend_cnt_r == 2'd0 && !paused;
    wire       send_data = txq_ready && txq_valid;
    assign tx_start  = start_r;
    assign tx_char   = tx_char_r;

    assign store_valid      = store_v_r;
    assign store_data       = store_d_r;
    assign store_parity_err = store_p_r;
    assign flow_irq         = cts_int_r || xoff_int_r;

    // ---------------- status views ----------------
    wire [7:0] fsr_v = {3'b000, tx_xoff_r, 2'b00, cts_gate & cts_high, rx_xoff_r};
    wire [5:0] isr_c = cts_int_r ? ISR_CTS : (xoff_int_r ? ISR_XOFF : ISR_NONE);
    wire [7:0] msr_v = {3'b000, !cts_high, 3'b000, cts_delta_r};
    // empty bits follow only the fifo space, never the pause state
    wire [7:0] lsr_v = {1'b0, tx_space, tx_space, 5'b00000};

    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            OFS_EFR:   rd_mux = {24'h000000, efr_r};
            OFS_IER:   rd_mux = {24'h000000, ier_r};
            OFS_FCR:   rd_mux = {24'h000000, fcr_r};
            OFS_MCR:   rd_mux = {24'h000000, mcr_r};
            OFS_MODE:  rd_mux = {24'h000000, mode_r};
            OFS_UPPER: rd_mux = {23'h0, upper_eff};
            OFS_LOWER: rd_mux = {23'h0, lower_eff};
            OFS_RESUME_CHAR_FIRST:  rd_mux = {24'h000000, resume_char_first_r};
            OFS_RESUME_CHAR_SECOND:  rd_mux = {24'h000000, resume_char_second_r};
            OFS_PAUSE_CHAR_FIRST: rd_mux = {24'h000000, pause_char_first_r};
            OFS_PAUSE_CHAR_SECOND: rd_mux = {24'h000000, pause_char_second_r};
            OFS_FSR:   rd_mux = {24'h000000, fsr_v};
            OFS_ISR:   rd_mux = {26'h0, isr_c};
            OFS_MSR:   rd_mux = {24'h000000, msr_v};
            OFS_LSR:   rd_mux = {24'h000000, lsr_v};
            default: begin
                rd_mux = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // ---------------- bus handshake ----------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= AXI_OKAY;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= AXI_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_hold_r) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_r) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_ok ? AXI_OKAY : AXI_SLVERR;
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_mux;
                rresp_r  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ---------------- writable registers ----------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            efr_r <= RST_REG;  ier_r <= RST_REG;  fcr_r <= RST_REG;
            mcr_r <= RST_REG;  mode_r <= RST_REG;
            upper_r <= RST_UPPER;  lower_r <= RST_LOWER;
            resume_char_first_r <= RST_XON;  resume_char_second_r <= RST_XON;
            pause_char_first_r <= RST_XOFF;  pause_char_second_r <= RST_XOFF;
        end else if (wr_b0) begin
            unique case (aw_addr_r)
                OFS_EFR:   efr_r  <= wd;
                OFS_IER:   ier_r  <= wd;
                OFS_FCR:   fcr_r  <= wd;
                OFS_MCR:   mcr_r  <= wd;
                OFS_MODE:  mode_r <= wd;
                OFS_UPPER: if (big_mode) upper_r <= {1'b0, wd};
                OFS_LOWER: if (big_mode) lower_r <= {1'b0, wd};
                OFS_RESUME_CHAR_FIRST:  resume_char_first_r  <= wd;
                OFS_RESUME_CHAR_SECOND:  resume_char_second_r  <= wd;
                OFS_PAUSE_CHAR_FIRST: pause_char_first_r <= wd;
                OFS_PAUSE_CHAR_SECOND: pause_char_second_r <= wd;
                default: ;
            endcase
        end
    end

    // ---------------- cts synchroniser and interrupts ----------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cts_meta_r  <= 1'b1;
            cts_sync_r  <= 1'b1;
            cts_prev_r  <= 1'b1;
            cts_int_r   <= 1'b0;
            cts_delta_r <= 1'b0;
            xoff_int_r  <= 1'b0;
        end else begin
            cts_meta_r <= cts_n;
            cts_sync_r <= cts_meta_r;
            cts_prev_r <= cts_sync_r;
            // set beats the clearing read in the same cycle
            if (cts_gate && ier_r[IER_CTS_INT] && cts_sync_r && !cts_prev_r)
                cts_int_r <= 1'b1;
            else if (rd_msr)
                cts_int_r <= 1'b0;
            if (cts_sync_r != cts_prev_r)
                cts_delta_r <= 1'b1;
            else if (rd_msr)
                cts_delta_r <= 1'b0;
            if (go_xoff && ier_r[IER_XOFF_INT])
                xoff_int_r <= 1'b1;
            else if (rd_isr || go_xon)
                xoff_int_r <= 1'b0;
        end
    end

    // ---------------- transmit side ----------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tx_xoff_r  <= 1'b0;
            pend_cnt_r <= 2'd0;
            pend_off_r <= 1'b0;
            start_r    <= 1'b0;
            tx_char_r  <= 8'h00;
        end else begin
            start_r <= send_flow || send_data;
            if (send_flow)
                tx_char_r <= flow_char;
            else if (send_data)
                tx_char_r <= txq_data;
            if (!tx_sw_on) begin
                tx_xoff_r  <= 1'b0;
                pend_cnt_r <= 2'd0;
            end else if (tx_go_off) begin
                tx_xoff_r  <= 1'b1;
                pend_off_r <= 1'b1;
                pend_cnt_r <= pair_tx ? 2'd2 : 2'd1;
            end else if (tx_go_on) begin
                tx_xoff_r  <= 1'b0;
                pend_off_r <= 1'b0;
                pend_cnt_r <= pair_tx ? 2'd2 : 2'd1;
            end else if (send_flow) begin
                pend_cnt_r <= pend_cnt_r - 2'd1;
            end
        end
    end

    // ---------------- receive side ----------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rx_xoff_r   <= 1'b0;
            held_on_r   <= 1'b0;
            held_off_r  <= 1'b0;
            held_char_r <= 8'h00;
            store_v_r   <= 1'b0;
            store_d_r   <= 8'h00;
            store_p_r   <= 1'b0;
            defer_v_r   <= 1'b0;
            defer_d_r   <= 8'h00;
            defer_p_r   <= 1'b0;
        end else begin
            if (!rx_sw_on)
                rx_xoff_r <= 1'b0;
            else if (go_xon)
                rx_xoff_r <= 1'b0;
            else if (go_xoff)
                rx_xoff_r <= 1'b1;
            if (!rx_two) begin
                held_on_r  <= 1'b0;
                held_off_r <= 1'b0;
            end else if (rx_valid) begin
                // a fresh first replaces any held one, which is then dropped
                held_on_r   <= first_hit && is_on1;
                held_off_r  <= first_hit && is_off1;
                held_char_r <= rx_data;
            end
            // a flushed first goes out now, the current char one cycle later
            defer_v_r <= flush;
            defer_d_r <= rx_data;
            defer_p_r <= rx_parity_err;
            if (flush) begin
                store_v_r <= 1'b1;
                store_d_r <= held_char_r;
                store_p_r <= 1'b0;
            end else if (rx_valid && !consumed) begin
                store_v_r <= 1'b1;
                store_d_r <= rx_data;
                store_p_r <= rx_parity_err;
            end else begin
                store_v_r <= defer_v_r;
                store_d_r <= defer_d_r;
                store_p_r <= defer_p_r;
            end
        end
    end

    // ---------------- assertions ----------------
    cts_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        (cts_gate && cts_sync_r) |-> !txq_ready) else $error("data released while cts high");
    cts_irq_a: assert property (@(posedge clock) disable iff (sys_rst)
        (cts_gate && ier_r[IER_CTS_INT] && $rose(cts_sync_r)) |=> cts_int_r)
        else $error("cts rise did not interrupt");
    xoff_send_a: assert property (@(posedge clock) disable iff (sys_rst)
        tx_go_off |=> (tx_xoff_r && pend_off_r && pend_cnt_r != 2'd0))
        else $error("xoff not queued above upper");
    xon_wait_a: assert property (@(posedge clock) disable iff (sys_rst)
        (tx_sw_on && tx_xoff_r && rx_count != lower_eff) |=> tx_xoff_r)
        else $error("xon left before lower reached");
    rx_pause_a: assert property (@(posedge clock) disable iff (sys_rst)
        (rx_sw_on && rx_xoff_r) |-> !txq_ready) else $error("data sent in xoff state");
    xoff_irq_a: assert property (@(posedge clock) disable iff (sys_rst)
        (go_xoff && ier_r[IER_XOFF_INT]) |=> (xoff_int_r && rx_xoff_r))
        else $error("xoff receipt lost");
    xon_state_a: assert property (@(posedge clock) disable iff (sys_rst)
        go_xon |=> (!rx_xoff_r && !xoff_int_r)) else $error("xon did not resume");
    flow_first_a: assert property (@(posedge clock) disable iff (sys_rst)
        (pend_cnt_r != 2'd0) |-> !send_data) else $error("data passed pending flow char");
    pass_thru_a: assert property (@(posedge clock) disable iff (sys_rst)
        (rx_valid && !rx_sw_on) |=> (store_v_r && store_d_r == $past(rx_data)))
        else $error("plain char not stored");

    xoff_sent_c: cover property (@(posedge clock) disable iff (sys_rst) send_flow && pend_off_r);
    pair_xon_c:  cover property (@(posedge clock) disable iff (sys_rst) rx_valid && rx_two && pair_on);
    cts_stop_c:  cover property (@(posedge clock) disable iff (sys_rst) cts_gate && $rose(cts_sync_r) && tx_busy);
endmodule
`default_nettype wire

// ---- tb/uart_flow_peer.sv ----
`default_nettype none
module uart_flow_peer (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic tx_start,
    output logic      tx_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    // short frame keeps the run brief; a real frame only widens the busy window
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) cnt_r <= 4'h0;
        else if (tx_start) cnt_r <= 4'h6;
        else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    end
    assign tx_busy = (cnt_r != 4'h0);
endmodule
`default_nettype wire

// ---- tb/uart_flow_control_bench.sv ----
`default_nettype none
module uart_flow_control_bench
    import uart_flow_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'h0, sys_rst = 1'h1, cts_n = 1'h0, rx_valid = 1'h0, rx_parity_err = 1'h0, txq_valid = 1'h0;
    logic tx_space = 1'h1;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, rx_data = 8'h0, txq_data = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, seed = 32'h827b3a43;
    logic [8:0] rx_count = 9'h0;
    logic awready, wready, bvalid, arready, rvalid, store_valid, store_perr, txq_ready, tx_busy, tx_start, flow_irq;
    logic [1:0] bresp, rresp;
    logic [7:0] store_data, tx_char;
    logic [10:0] exp_q[3][$];
    logic [8:0] up_t[4] = '{UP_T0, UP_T1, UP_T2, UP_T3};
    logic [8:0] lo_t[4] = '{LO_T0, LO_T1, LO_T2, LO_T3};
    int err_total = 0, checks_done = 0, cyc = 0;
    always #2.5 clock = ~clock;
    uart_flow_control dut_u (.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cts_n(cts_n), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_parity_err(rx_parity_err), .rx_count(rx_count), .store_valid(store_valid),
        .store_data(store_data), .store_parity_err(store_perr), .txq_valid(txq_valid), .txq_data(txq_data),
        .txq_ready(txq_ready), .tx_space(tx_space), .tx_busy(tx_busy), .tx_start(tx_start), .tx_char(tx_char),
        .flow_irq(flow_irq));
    uart_flow_peer peer_u (.clock(clock), .sys_rst(sys_rst), .tx_start(tx_start), .tx_busy(tx_busy));
    // bit 6 set keeps random data clear of every flow character in use
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0] | 8'h40;
    endfunction
    task automatic chk(input logic [10:0] e, input logic [10:0] g);
        checks_done++;
        if (e !== g) begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic pop(input int k, input logic [10:0] g);
        logic [10:0] e;
        if (exp_q[k].size() == 0) e = 11'h7ff;
        else e = exp_q[k].pop_front();
        if (e[10]) chk(e, g);
    endtask
    always @(posedge clock) begin
        if (tx_start) pop(0, {3'h4, tx_char});
        if (store_valid) pop(1, {2'h2, store_perr, store_data});
        if (rvalid && rready) pop(2, {1'h1, rresp, rdata[7:0]});
        if (bvalid && bready) pop(2, {1'h1, bresp, 8'h00});
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        exp_q[2].push_back({1'h1, AXI_OKAY, 8'h00});
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        do begin
            @(posedge clock);
            if (awready && awvalid) awvalid <= 1'h0;
            if (wready && wvalid) wvalid <= 1'h0;
            if (bvalid) bready <= 1'h0;
        end while (awvalid || wvalid || bready);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r, input logic c);
        exp_q[2].push_back({c, r, d});
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        do begin
            @(posedge clock);
            if (arready && arvalid) arvalid <= 1'h0;
            if (rvalid) rready <= 1'h0;
        end while (arvalid || rready);
    endtask
    task automatic rx(input logic [7:0] d, input logic p);
        rx_data <= d; rx_parity_err <= p; rx_valid <= 1'h1;
        @(posedge clock);
        rx_valid <= 1'h0;
        repeat (4) @(posedge clock);
    endtask
    task automatic send(input logic [7:0] d);
        txq_data <= d; txq_valid <= 1'h1;
        do @(posedge clock); while (!txq_ready);
        txq_valid <= 1'h0;
    endtask
    initial begin
        logic [7:0] c;
        repeat (4) @(posedge clock);
        sys_rst <= 1'h0;
        @(posedge clock);
        rd(OFS_EFR, 8'h00, AXI_OKAY, 1'h1);
        rd(OFS_PAUSE_CHAR_SECOND, RST_XOFF, AXI_OKAY, 1'h1);
        rd(8'h3c, 8'h00, AXI_SLVERR, 1'h1);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_FCR, {i[1:0], i[1:0], 4'h0});
            rd(OFS_UPPER, up_t[i][7:0], AXI_OKAY, 1'h1);
            rd(OFS_LOWER, lo_t[i][7:0], AXI_OKAY, 1'h1);
        end
        wr(OFS_IER, 8'h80);
        wr(OFS_EFR, 8'h80);
        cts_n <= 1'h1;
        c = rnd();
        // let the pin pass the synchroniser before offering data
        repeat (3) @(posedge clock);
        txq_data <= c; txq_valid <= 1'h1;
        repeat (4) @(posedge clock);
        rd(OFS_FSR, 8'h02, AXI_OKAY, 1'h1);
        rd(OFS_ISR, {2'h0, ISR_CTS}, AXI_OKAY, 1'h1);
        chk(11'h1, 11'(flow_irq));
        rd(OFS_LSR, 8'h60, AXI_OKAY, 1'h1);
        tx_space <= 1'h0;
        rd(OFS_LSR, 8'h00, AXI_OKAY, 1'h1);
        tx_space <= 1'h1;
        rd(OFS_MSR, 8'h01, AXI_OKAY, 1'h1);
        chk(11'h0, 11'(flow_irq));
        rd(OFS_ISR, {2'h0, ISR_NONE}, AXI_OKAY, 1'h1);
        exp_q[0].push_back({3'h4, c});
        cts_n <= 1'h0;
        send(c);
        wr(OFS_EFR, 8'h02);
        wr(OFS_IER, 8'h20);
        rx(RST_XOFF, 1'h0);
        rd(OFS_FSR, 8'h01, AXI_OKAY, 1'h1);
        rd(OFS_ISR, {2'h0, ISR_XOFF}, AXI_OKAY, 1'h1);
        rd(OFS_ISR, {2'h0, ISR_NONE}, AXI_OKAY, 1'h1);
        c = rnd();
        txq_data <= c; txq_valid <= 1'h1;
        repeat (8) @(posedge clock);
        exp_q[0].push_back({3'h4, c});
        fork
            rx(RST_XON, 1'h1);
            send(c);
        join
        c = rnd();
        exp_q[1].push_back({3'h5, c});
        rx(c, 1'h1);
        wr(OFS_FCR, 8'h00);
        wr(OFS_EFR, 8'h08);
        exp_q[0].push_back({3'h4, RST_XOFF});
        rx_count <= 9'h009;
        repeat (12) @(posedge clock);
        rd(OFS_FSR, 8'h10, AXI_OKAY, 1'h1);
        exp_q[0].push_back({3'h4, RST_XON});
        rx_count <= 9'h000;
        repeat (20) @(posedge clock);
        wr(OFS_MODE, 8'h01);
        wr(OFS_UPPER, 8'h20);
        wr(OFS_LOWER, 8'h04);
        rd(OFS_UPPER, 8'h20, AXI_OKAY, 1'h1);
        wr(OFS_PAUSE_CHAR_SECOND, 8'h2b);
        wr(OFS_EFR, 8'h0c);
        exp_q[0].push_back({3'h4, RST_XOFF});
        exp_q[0].push_back({3'h4, 8'h2b});
        rx_count <= 9'h021;
        repeat (30) @(posedge clock);
        exp_q[0].push_back({3'h4, RST_XON});
        exp_q[0].push_back({3'h4, RST_XON});
        rx_count <= 9'h004;
        repeat (30) @(posedge clock);
        wr(OFS_EFR, 8'h03);
        rx(RST_XOFF, 1'h0);
        rx(8'h2b, 1'h0);
        rd(OFS_FSR, 8'h01, AXI_OKAY, 1'h1);
        chk(11'h1, 11'(flow_irq));
        exp_q[1].push_back({3'h4, 8'h2b});
        rx(8'h2b, 1'h0);
        wr(OFS_MCR, 8'h20);
        c = rnd();
        exp_q[1].push_back({3'h4, c});
        rx(c, 1'h0);
        rd(OFS_FSR, 8'h00, AXI_OKAY, 1'h1);
        rd(OFS_ISR, {2'h0, ISR_NONE}, AXI_OKAY, 1'h1);
        for (int k = 0; k < 3; k++) chk(11'h0, 11'(exp_q[k].size()));
        summarize();
    end
endmodule
`default_nettype wire
